// >>> core/sensor_reset_selftest_error_ctrl.v
// Supply supervision, startup sequencing, reset, self-test and error flag logic
// Contract
// - Keep powerGood low while supply below threshold; then start startup sequence.
// - On supply drop, powerGood low until supply returns, then full new startup.
// - Error flag high from power-on until startup sequence completes.
// - Operational about 40 us after startup begins.
// - External reset is active low; pulled up so open pin means no reset.
// - During external reset, force both differential outputs to midpoint; here forced only while powerGood is high.
// - Error flag high for whole external reset phase.
// - Error flag high whenever powerGood is low.
// - Self-test input active high; pulled down so open pin means inactive.
// - While self-test active, superimpose about 24 Hz square wave on outputs.
// - On overload, reset readout and restart it until input back in range.
// - Error flag high during acceleration overload.
// - High error flag means outputs invalid; host ignores outputs meanwhile.
`timescale 1ns/1ps
`include "sensor_supervisor_defines.vh"

module sensor_reset_selftest_error_ctrl #(
  parameter integer STARTUP_CYCLES = `STARTUP_CYCLES,
  parameter integer SELFTEST_HALF_CYCLES = `SELFTEST_HALF_CYCLES
)(
  input wire clk_sys,
  input wire rst_n,
  input wire supplyAboveThreshold,
  input wire resetPin_n,
  input wire selftest_request,
  input wire overloadDetect,
  output wire powerGood,
  output wire errorFlag,
  output reg forceMidpoint_r,
  output reg readoutReset_r,
  output reg selftestWave_r,
  output wire irq,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  localparam [2:0] ST_OFF = 3'h0;
  localparam [2:0] ST_STARTUP = 3'h1;
  localparam [2:0] ST_RUN = 3'h2;
  localparam [2:0] ST_RESET = 3'h3;
  localparam [2:0] ST_OVERLOAD = 3'h4;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Bit order: supply, reset_n, selftest, overload
  reg [3:0] syncA_r;
  reg [3:0] syncB_r;
  // Reset values mimic the pin pulls: reset pin high, self-test low
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      syncA_r <= `SYNC_RST_VAL;
      syncB_r <= `SYNC_RST_VAL;
    end
    else
    begin
      syncA_r <= {overloadDetect, selftest_request, resetPin_n, supplyAboveThreshold};
      syncB_r <= syncA_r;
    end
  end
  wire supplyOk = syncB_r[0];
  wire extResetActive = ~syncB_r[1];
  wire selftestReq = syncB_r[2];
  wire overload = syncB_r[3];

  // ----------------------------------------
  // Registers written by software
  // ----------------------------------------
  reg [1:0] ctrl_r;
  reg [`EV_W-1:0] irqStatus_r;
  reg [`EV_W-1:0] irqMask_r;
  wire swReset = ctrl_r[`CTRL_SW_RST];
  wire resetPhase = extResetActive | swReset;

  // ----------------------------------------
  // Startup sequencer
  // ----------------------------------------
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [31:0] startCnt_r;
  wire startDone = (startCnt_r == STARTUP_CYCLES - 1);
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF:
        if (supplyOk)
          state_nxt = ST_STARTUP;
      ST_STARTUP:
        if (startDone)
          state_nxt = ST_RUN;
      ST_RUN: state_nxt = ST_RUN;
      ST_RESET:
        if (!resetPhase)
          state_nxt = ST_STARTUP;
      ST_OVERLOAD:
        if (!overload)
          state_nxt = ST_STARTUP;
      default: state_nxt = ST_OFF;
    endcase
    // Priority: supply, then reset, then overload
    if (!supplyOk)
      state_nxt = ST_OFF;
    else if (resetPhase)
      state_nxt = ST_RESET;
    else if (overload && state_r != ST_OFF)
      state_nxt = ST_OVERLOAD;
  end
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= ST_OFF;
      startCnt_r <= 32'h00000000;
    end
    else
    begin
      state_r <= state_nxt;
      // Counter restarts on every entry so a restart is always complete
      if (state_r == ST_STARTUP && state_nxt == ST_STARTUP)
        startCnt_r <= startCnt_r + 32'h00000001;
      else
        startCnt_r <= 32'h00000000;
    end
  end
  // Power-good follows the comparator directly after synchronisation
  assign powerGood = supplyOk;
  // Combinational OR of the causes so the flag never lags a cause
  assign errorFlag = (state_r != ST_RUN) | ~supplyOk |
    resetPhase | overload;
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      forceMidpoint_r <= 1'b0;
      readoutReset_r <= 1'b1;
    end
    else
    begin
      forceMidpoint_r <= supplyOk & resetPhase;
      // Readout held in reset in every state but startup and run
      readoutReset_r <= (state_nxt != ST_STARTUP) & (state_nxt != ST_RUN);
    end
  end

  // ----------------------------------------
  // Self-test stimulus
  // ----------------------------------------
  // The stimulus adds to real motion, so the host must keep the sensor still
  reg [31:0] stCnt_r;
  reg stPhase_r;
  wire stActive = selftestReq & ctrl_r[`CTRL_ST_EN] & (state_r == ST_RUN);
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stCnt_r <= 32'h00000000;
      stPhase_r <= 1'b0;
      selftestWave_r <= 1'b0;
    end
    else
    begin
      if (!stActive)
      begin
        stCnt_r <= 32'h00000000;
        stPhase_r <= 1'b0;
      end
      else if (stCnt_r == SELFTEST_HALF_CYCLES - 1)
      begin
        stCnt_r <= 32'h00000000;
        stPhase_r <= ~stPhase_r;
      end
      else
        stCnt_r <= stCnt_r + 32'h00000001;
      selftestWave_r <= stActive & stPhase_r;
    end
  end

  // ----------------------------------------
  // Event capture
  // ----------------------------------------
  // Bit order: supply, reset phase, overload, self-test
  reg [3:0] causeD_r;
  reg [2:0] stateD_r;
  wire [`EV_W-1:0] events;
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      causeD_r <= 4'h0;
      stateD_r <= ST_OFF;
    end
    else
    begin
      causeD_r <= {stActive, overload, resetPhase, supplyOk};
      stateD_r <= state_r;
    end
  end

  assign events[`EV_STARTED] = (state_r == ST_RUN) & (stateD_r != ST_RUN);
  assign events[`EV_BROWNOUT] = causeD_r[0] & ~supplyOk;
  assign events[`EV_OVERLOAD] = overload & ~causeD_r[2];
  assign events[`EV_EXTRST] = resetPhase & ~causeD_r[1];
  assign events[`EV_SELFTEST] = stActive & ~causeD_r[3];
  assign irq = |(irqStatus_r & irqMask_r);

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  reg awHeld_r;
  reg wHeld_r;
  reg [7:0] awAddr_r;
  reg [31:0] wData_r;
  reg [3:0] wStrb_r;
  assign s_axi_awready = ~awHeld_r & ~s_axi_bvalid;
  assign s_axi_wready = ~wHeld_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  function mapped;
    input [7:0] addr;
    begin
      mapped = (addr == `OFS_CTRL) | (addr == `OFS_STATUS) |
        (addr == `OFS_IRQ_STATUS) | (addr == `OFS_IRQ_MASK);
    end
  endfunction
  wire awTake = s_axi_awvalid & s_axi_awready;
  wire wTake = s_axi_wvalid & s_axi_wready;
  wire awHave = awHeld_r | awTake;
  wire wHave = wHeld_r | wTake;
  wire [7:0] wrAddr = awHeld_r ? awAddr_r : s_axi_awaddr;
  wire [31:0] wrData = wHeld_r ? wData_r : s_axi_wdata;
  wire [3:0] wrStrb = wHeld_r ? wStrb_r : s_axi_wstrb;
  wire doWrite = awHave & wHave & ~s_axi_bvalid;
  wire lane0 = doWrite & wrStrb[0];
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else
    begin
      if (awTake)
        awAddr_r <= s_axi_awaddr;
      if (wTake)
      begin
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(wrAddr) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else
      begin
        awHeld_r <= awHave;
        wHeld_r <= wHave;
        if (s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Hardware set wins over a write-one clear in the same cycle
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r <= `CTRL_RST_VAL;
      irqStatus_r <= {`EV_W{1'b0}};
      irqMask_r <= `MASK_RST_VAL;
    end
    else
    begin
      if (lane0 && wrAddr == `OFS_CTRL)
        ctrl_r <= wrData[1:0];
      if (lane0 && wrAddr == `OFS_IRQ_MASK)
        irqMask_r <= wrData[`EV_W-1:0];
      if (lane0 && wrAddr == `OFS_IRQ_STATUS)
        irqStatus_r <= (irqStatus_r & ~wrData[`EV_W-1:0]) | events;
      else
        irqStatus_r <= irqStatus_r | events;
    end
  end
  wire [31:0] statusWord = {21'h000000, state_r, 3'h0, stActive, overload,
    resetPhase, errorFlag, supplyOk};
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      case (s_axi_araddr)
        `OFS_CTRL: s_axi_rdata <= {30'h00000000, ctrl_r};
        `OFS_STATUS: s_axi_rdata <= statusWord;
        `OFS_IRQ_STATUS: s_axi_rdata <= {27'h0000000, irqStatus_r};
        `OFS_IRQ_MASK: s_axi_rdata <= {27'h0000000, irqMask_r};
        default: s_axi_rdata <= 32'h00000000;
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule

// >>> core/sensor_supervisor_defines.vh
// Constants of the sensor supervision block: timing, register map, field layout
`ifndef SENSOR_SUPERVISOR_DEFINES_VH
`define SENSOR_SUPERVISOR_DEFINES_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_FREQ_HZ 250000000
`define STARTUP_TIME_US 40
`define STARTUP_CYCLES ((`CLK_FREQ_HZ / 1000000) * `STARTUP_TIME_US)
`define SELFTEST_FREQ_HZ 24
`define SELFTEST_HALF_CYCLES (`CLK_FREQ_HZ / (2 * `SELFTEST_FREQ_HZ))

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_IRQ_STATUS 8'h08
`define OFS_IRQ_MASK 8'h0C

// ----------------------------------------
// Fields
// ----------------------------------------
`define CTRL_ST_EN 0
`define CTRL_SW_RST 1
`define CTRL_RST_VAL 2'h1
`define STAT_PG 0
`define STAT_ERR 1
`define STAT_EXTRST 2
`define STAT_OVL 3
`define STAT_ST 4
`define STAT_STATE_LO 8
`define EV_STARTED 0
`define EV_BROWNOUT 1
`define EV_OVERLOAD 2
`define EV_EXTRST 3
`define EV_SELFTEST 4
`define EV_W 5
`define MASK_RST_VAL 5'h00
`define SYNC_RST_VAL 4'h2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> testbench/host_model.sv
// Host controller model driving the reset and self-test pins
`timescale 1ns/1ps
module host_model (
  input wire clk_sys,
  input wire wantRst,
  input wire wantSt,
  input wire atRest,
  input wire errorFlag,
  output reg resetPin_n,
  output reg selftest_request,
  output reg outputsUsable
);
  initial
  begin
    resetPin_n = 1'h1;
    selftest_request = 1'h0;
    outputsUsable = 1'h0;
  end
  always @(posedge clk_sys)
  begin
    // An undriven pin rests at its pull level
    resetPin_n <= !wantRst;
    // Stimulus adds to real motion, so only ask for it at rest
    selftest_request <= wantSt && atRest;
    outputsUsable <= !errorFlag;
  end
endmodule

// >>> testbench/sensor_ctrl_props.sv
// Port assertions for the supervision, reset and self-test block
`timescale 1ns/1ps
module sensor_ctrl_props (
  input wire clk_sys,
  input wire rst_n,
  input wire resetPin_n,
  input wire selftest_request,
  input wire overloadDetect,
  input wire powerGood,
  input wire errorFlag,
  input wire forceMidpoint_r,
  input wire readoutReset_r,
  input wire selftestWave_r
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  property p_pgErr; !powerGood |-> errorFlag; endproperty
  a_pgErr: assert property (p_pgErr) else $error("flag low, supply bad");
  property p_start; $rose(powerGood) |-> errorFlag[*8]; endproperty
  a_start: assert property (p_start) else $error("startup too short");
  // Pins pass two flops, so the flag follows them two samples late
  property p_drop;
    $fell(errorFlag) |-> powerGood && $past(resetPin_n, 2) && !$past(overloadDetect, 2);
  endproperty
  a_drop: assert property (p_drop) else $error("flag fell with a cause");
  property p_rst; !resetPin_n[*3] |-> errorFlag; endproperty
  a_rst: assert property (p_rst) else $error("flag low in reset");
  property p_mid; (!resetPin_n && powerGood)[*5] |-> forceMidpoint_r; endproperty
  a_mid: assert property (p_mid) else $error("outputs not at midpoint");
  property p_ovl; overloadDetect[*3] |-> errorFlag; endproperty
  a_ovl: assert property (p_ovl) else $error("flag low in overload");
  property p_ro; overloadDetect[*4] |-> readoutReset_r; endproperty
  a_ro: assert property (p_ro) else $error("readout not reset");
  property p_st; !selftest_request[*5] |-> !selftestWave_r; endproperty
  a_st: assert property (p_st) else $error("wave without request");
  c_ready: cover property ($fell(errorFlag));
  c_ovl: cover property ($rose(readoutReset_r));
  c_wave: cover property ($rose(selftestWave_r));
endmodule
bind sensor_reset_selftest_error_ctrl sensor_ctrl_props chkr (.clk_sys(clk_sys), .rst_n(rst_n),
  .resetPin_n(resetPin_n), .selftest_request(selftest_request), .overloadDetect(overloadDetect),
  .powerGood(powerGood), .errorFlag(errorFlag), .forceMidpoint_r(forceMidpoint_r),
  .readoutReset_r(readoutReset_r), .selftestWave_r(selftestWave_r));

// >>> testbench/sensor_reset_selftest_error_ctrl_bench.sv
// Self-checking bench for the supervision, reset and self-test block
`timescale 1ns/1ps
`include "sensor_supervisor_defines.vh"
module sensor_reset_selftest_error_ctrl_bench;
  localparam integer SU = 20;
  localparam integer HALF = 8;
  reg clk_sys, rst_n, supplyAboveThreshold, overloadDetect, wantRst, wantSt;
  reg [7:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata;
  reg s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire resetPin_n, selftest_request, powerGood, errorFlag, forceMidpoint_r, readoutReset_r;
  wire selftestWave_r, irq, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, outputsUsable;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  integer n_errors, check_count, i;
  logic [31:0] rd;
  logic [1:0] rsp;
  sensor_reset_selftest_error_ctrl #(.STARTUP_CYCLES(SU), .SELFTEST_HALF_CYCLES(HALF)) uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .supplyAboveThreshold(supplyAboveThreshold),
    .resetPin_n(resetPin_n), .selftest_request(selftest_request), .overloadDetect(overloadDetect),
    .powerGood(powerGood), .errorFlag(errorFlag), .forceMidpoint_r(forceMidpoint_r),
    .readoutReset_r(readoutReset_r), .selftestWave_r(selftestWave_r), .irq(irq),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  host_model host (.clk_sys(clk_sys), .wantRst(wantRst), .wantSt(wantSt),
    .atRest(!overloadDetect), .errorFlag(errorFlag), .resetPin_n(resetPin_n),
    .selftest_request(selftest_request), .outputsUsable(outputsUsable));
  initial
  begin
    clk_sys = 1'h0;
    forever #2 clk_sys = ~clk_sys;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count = check_count + 1;
    if (got !== exp)
      n_errors = n_errors + 1;
    if (got !== exp)
      $display("BAD %0t got %h expected %h", $time, got, exp);
  endtask
  task finish_test;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw && w))
    begin
      @(posedge clk_sys);
      if (!aw && s_axi_awready === 1'h1)
        s_axi_awvalid <= 1'h0;
      if (!aw && s_axi_awready === 1'h1)
        aw = 1;
      if (!w && s_axi_wready === 1'h1)
        s_axi_wvalid <= 1'h0;
      if (!w && s_axi_wready === 1'h1)
        w = 1;
    end
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  // Bounded wait until the outputs become valid; returns cycles waited
  task waitReady(output integer n);
    n = 0;
    while (errorFlag !== 1'h0 && n < 500)
    begin
      @(posedge clk_sys);
      n = n + 1;
    end
    chk(errorFlag, 0);
  endtask
  task waitWave(input logic v);
    for (i = 0; i < 100 && selftestWave_r !== v; i++) @(posedge clk_sys);
    chk(selftestWave_r, v);
  endtask
  initial
  begin
    #20000;
    n_errors = n_errors + 1;
    finish_test;
  end
  initial
  begin
    n_errors = 0;
    check_count = 0;
    {rst_n, supplyAboveThreshold, overloadDetect, wantRst, wantSt} = 5'h00;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'h1;
    @(posedge clk_sys);
    axr(`OFS_CTRL, rd, rsp);
    chk(rd[1:0], `CTRL_RST_VAL);
    axr(`OFS_IRQ_MASK, rd, rsp);
    chk(rd[4:0], `MASK_RST_VAL);
    chk({powerGood, errorFlag}, 2'h1);
    supplyAboveThreshold <= 1'h1;
    waitReady(i);
    chk(i >= SU + 2 && i <= SU + 6, 1);
    axr(`OFS_STATUS, rd, rsp);
    chk(rsp, `RESP_OKAY);
    chk(rd, 32'h00000201);
    chk(outputsUsable, 1);
    axr(`OFS_IRQ_STATUS, rd, rsp);
    chk({irq, rd[4:0]}, 6'h01);
    axw(`OFS_IRQ_MASK, 32'h1F, rsp);
    chk(irq, 1);
    axw(`OFS_IRQ_STATUS, 32'h1F, rsp);
    chk(irq, 0);
    wantSt <= 1'h1;
    waitWave(1);
    waitWave(0);
    waitWave(1);
    chk(i, HALF);
    wantSt <= 1'h0;
    repeat (6) @(posedge clk_sys);
    chk(selftestWave_r, 0);
    wantRst <= 1'h1;
    repeat (6) @(posedge clk_sys);
    chk({errorFlag, forceMidpoint_r}, 2'h3);
    wantRst <= 1'h0;
    waitReady(i);
    chk({i >= SU, forceMidpoint_r}, 2'h2);
    overloadDetect <= 1'h1;
    repeat (SU + 10) @(posedge clk_sys);
    chk({errorFlag, readoutReset_r}, 2'h3);
    overloadDetect <= 1'h0;
    waitReady(i);
    chk(i >= SU, 1);
    supplyAboveThreshold <= 1'h0;
    repeat (4) @(posedge clk_sys);
    chk({powerGood, errorFlag}, 2'h1);
    supplyAboveThreshold <= 1'h1;
    waitReady(i);
    chk(i >= SU + 2, 1);
    axr(`OFS_IRQ_STATUS, rd, rsp);
    chk({irq, rd[4:0]}, 6'h3F);
    axw(`OFS_IRQ_MASK, 32'h0, rsp);
    chk(irq, 0);
    axr(8'h10, rd, rsp);
    chk(rsp, `RESP_SLVERR);
    chk(rd, 32'h0);
    axw(8'h10, 32'h3, rsp);
    chk(rsp, `RESP_SLVERR);
    // Software reset phase behaves like the reset pin
    axw(`OFS_CTRL, 32'h3, rsp);
    repeat (2) @(posedge clk_sys);
    chk({rsp, errorFlag, forceMidpoint_r, outputsUsable}, 5'h06);
    axw(`OFS_CTRL, 32'h1, rsp);
    waitReady(i);
    chk({i >= SU, forceMidpoint_r, readoutReset_r}, 3'h4);
    finish_test;
  end
endmodule
